/* File: core/gpio_consts.svh */
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

`define CFG_PA_LOW 32'h4000B000
`define CFG_PA_HIGH 32'h4000B004
`define CFG_PB_LOW 32'h4000B400
`define CFG_PB_HIGH 32'h4000B404
`define CFG_PC_LOW 32'h4000B800
`define CFG_PC_HIGH 32'h4000B804
`define DBG_CTL_ADDR 32'h4000BC00
`define DBG_STAT_ADDR 32'h4000BC04

`define CFG_RESET 16'h4444
`define CFG_WIDTH 16
`define NUM_CFG_REGS 6
`define NUM_PINS 24

`define CTL_DBG_DISABLE 0
`define CTL_REG_EN_OVR 1
`define CTL_TIM2_REMAP 2
`define CTL_WIDTH 3
`define CTL_RESET 3'h2

`define STAT_FORCED 0
`define STAT_SW_EN 1
`define STAT_BOOT 2

`define PIN_BOOT 5
`define PIN_REG_EN 7
`define PIN_TEST_RST 16
`define PIN_TEST_DO 18
`define PIN_TEST_DI 19
`define PIN_SWDIO 20

`endif

/* File: core/gpio_pkg.sv */
`default_nettype none
package gpio_pkg;
	typedef enum logic [3:0] {
		MODE_ANALOG = 4'h0,
		MODE_OUT_PP = 4'h1,
		MODE_IN_FLOAT = 4'h4,
		MODE_OUT_OD = 4'h5,
		MODE_IN_PULL = 4'h8,
		MODE_ALT_PP = 4'h9,
		MODE_ALT_OD = 4'hD
	} pin_mode_t;
endpackage
`default_nettype wire

/* File: core/gpio_pin_config_mux.sv */
// The implementer's own choice: register access over APB.
`include "gpio_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_config_mux (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [23:0] port_output_data,
	input wire logic [23:0] alt_out_data,
	input wire logic [3:0] timer_two_ch,
	input wire logic reg_en_drive,
	input wire logic debug_forced_in,
	input wire logic serial_wire_req,
	input wire logic four_wire_req,
	input wire logic test_data_out,
	input wire logic swdio_out,
	input wire logic swdio_drive,
	input wire logic [23:0] pin_in,
	output logic [23:0] pin_out,
	output logic [23:0] pin_oe_n,
	output logic [23:0] pin_pull_up,
	output logic [23:0] pin_pull_down,
	output logic [23:0] port_input_data
);

	logic [15:0] cfg_q [`NUM_CFG_REGS];
	logic [`CTL_WIDTH-1:0] ctl_q;
	logic boot_seen_q;
	logic boot_done_q;
	logic [31:0] prdata_q;
	logic hit_cfg;
	logic hit_ctl;
	logic hit_stat;
	logic [2:0] cfg_idx;
	logic wr_en;
	logic sw_active;
	logic four_wire_active;
	logic [2:0] status_val;
	logic [23:0] alt_src;
	gpio_pkg::pin_mode_t mode_d [`NUM_PINS];
	logic [23:0] out_d;
	logic [23:0] oe_n_d;
	logic [23:0] pu_d;
	logic [23:0] pd_d;
	logic [23:0] in_d;

	// address decode; unmapped addresses answer with pslverr
	always_comb begin
		hit_cfg = 1'b1;
		hit_ctl = 1'b0;
		hit_stat = 1'b0;
		cfg_idx = 3'h0;
		if (paddr == `CFG_PA_LOW) begin
			cfg_idx = 3'h0;
		end else if (paddr == `CFG_PA_HIGH) begin
			cfg_idx = 3'h1;
		end else if (paddr == `CFG_PB_LOW) begin
			cfg_idx = 3'h2;
		end else if (paddr == `CFG_PB_HIGH) begin
			cfg_idx = 3'h3;
		end else if (paddr == `CFG_PC_LOW) begin
			cfg_idx = 3'h4;
		end else if (paddr == `CFG_PC_HIGH) begin
			cfg_idx = 3'h5;
		end else if (paddr == `DBG_CTL_ADDR) begin
			hit_cfg = 1'b0;
			hit_ctl = 1'b1;
		end else if (paddr == `DBG_STAT_ADDR) begin
			hit_cfg = 1'b0;
			hit_stat = 1'b1;
		end else begin
			hit_cfg = 1'b0;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit_cfg || hit_ctl || hit_stat);
	assign wr_en = psel && penable && pwrite;
	assign prdata = prdata_q;

	// debugger disable overrides both debug port requests
	assign sw_active = serial_wire_req && !ctl_q[`CTL_DBG_DISABLE];
	assign four_wire_active = four_wire_req && !sw_active && !ctl_q[`CTL_DBG_DISABLE];
	always_comb begin
		status_val = 3'h0;
		status_val[`STAT_FORCED] = debug_forced_in;
		status_val[`STAT_SW_EN] = sw_active;
		status_val[`STAT_BOOT] = boot_seen_q;
	end

	// read data is captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= 32'h0;
			if (hit_cfg) begin
				prdata_q[15:0] <= cfg_q[cfg_idx];
			end else if (hit_ctl) begin
				prdata_q[`CTL_WIDTH-1:0] <= ctl_q;
			end else if (hit_stat) begin
				prdata_q[2:0] <= status_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < `NUM_CFG_REGS; r++) begin
				cfg_q[r] <= `CFG_RESET;
			end
		end else if (wr_en && hit_cfg) begin
			cfg_q[cfg_idx] <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= `CTL_RESET;
		end else if (wr_en && hit_ctl) begin
			ctl_q <= pwdata[`CTL_WIDTH-1:0];
		end
	end

	// boot pin is still pulled up on the first edge after release, so sample it there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_done_q <= 1'b0;
			boot_seen_q <= 1'b0;
		end else if (!boot_done_q) begin
			boot_done_q <= 1'b1;
			boot_seen_q <= !pin_in[`PIN_BOOT];
		end
	end

	// timer two channel order on port A is 1,3,4,2
	always_comb begin
		alt_src = alt_out_data;
		if (ctl_q[`CTL_TIM2_REMAP]) begin
			alt_src[12:9] = timer_two_ch;
		end else begin
			alt_src[0] = timer_two_ch[0];
			alt_src[1] = timer_two_ch[2];
			alt_src[2] = timer_two_ch[3];
			alt_src[3] = timer_two_ch[1];
		end
	end

	always_comb begin
		gpio_pkg::pin_mode_t m;
		logic ob;
		logic ab;
		m = gpio_pkg::MODE_IN_FLOAT;
		ob = 1'b0;
		ab = 1'b0;
		for (int i = 0; i < `NUM_PINS; i++) begin
			m = gpio_pkg::pin_mode_t'(cfg_q[i/4][(i%4)*4 +: 4]);
			ob = port_output_data[i];
			ab = alt_src[i];
			in_d[i] = (m == gpio_pkg::MODE_ANALOG) ? 1'b1 : pin_in[i];
			if (i == `PIN_REG_EN && ctl_q[`CTL_REG_EN_OVR]) begin
				m = gpio_pkg::MODE_ALT_OD;
				ab = reg_en_drive;
			end
			if (four_wire_active && (i == `PIN_TEST_RST || i == `PIN_TEST_DI)) begin
				m = gpio_pkg::MODE_IN_PULL;
				ob = 1'b1;
			end
			if (four_wire_active && i == `PIN_TEST_DO) begin
				m = gpio_pkg::MODE_ALT_PP;
				ab = test_data_out;
			end
			if (sw_active && i == `PIN_SWDIO) begin
				// direction is turned by the debugger bit by bit
				m = swdio_drive ? gpio_pkg::MODE_ALT_PP : gpio_pkg::MODE_IN_FLOAT;
				ab = swdio_out;
			end
			mode_d[i] = m;
			out_d[i] = 1'b0;
			oe_n_d[i] = 1'b1;
			pu_d[i] = 1'b0;
			pd_d[i] = 1'b0;
			case (m)
				gpio_pkg::MODE_OUT_PP: begin
					out_d[i] = ob;
					oe_n_d[i] = 1'b0;
				end
				gpio_pkg::MODE_OUT_OD: begin
					oe_n_d[i] = ob;
				end
				gpio_pkg::MODE_IN_PULL: begin
					pu_d[i] = ob;
					pd_d[i] = !ob;
				end
				gpio_pkg::MODE_ALT_PP: begin
					out_d[i] = ab;
					oe_n_d[i] = 1'b0;
				end
				gpio_pkg::MODE_ALT_OD: begin
					oe_n_d[i] = ab;
				end
				// analog, floating and reserved codes leave the pin undriven
				default: begin
					out_d[i] = 1'b0;
				end
			endcase
		end
	end

	// reset values leave only the boot pin pulled up, all else floating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 24'h000000;
			pin_oe_n <= 24'hFFFFFF;
			pin_pull_up <= 24'h000020;
			pin_pull_down <= 24'h000000;
		end else begin
			pin_out <= out_d;
			pin_oe_n <= oe_n_d;
			pin_pull_up <= pu_d;
			pin_pull_down <= pd_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_input_data <= 24'h000000;
		end else begin
			port_input_data <= in_d;
		end
	end

	status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && paddr == `DBG_STAT_ADDR
		|-> prdata == {29'h0, $past(status_val)})
		else $error("status read does not match flags");

	boot_flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		boot_done_q |=> $stable(boot_seen_q))
		else $error("boot flag changed after capture");

	dbg_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_q[`CTL_DBG_DISABLE] |-> !sw_active && !four_wire_active)
		else $error("debug port active while disabled");

	cfg_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_cfg |-> prdata[31:16] == 16'h0)
		else $error("config upper bits not zero");

	cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_cfg |=> cfg_q[$past(cfg_idx)] == $past(pwdata[15:0]))
		else $error("config write not read back");

	tdo_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		four_wire_active |=> !pin_oe_n[`PIN_TEST_DO] && pin_out[`PIN_TEST_DO] == $past(test_data_out))
		else $error("test data out not driven push-pull");

	for (genvar g = 0; g < `NUM_PINS; g++) begin : g_pin_chk
		analog_in_a: assert property (@(posedge pclk) disable iff (!presetn)
			cfg_q[g/4][(g%4)*4 +: 4] == 4'h0 |=> port_input_data[g])
			else $error("analog pin input not one");
		push_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
			mode_d[g] == gpio_pkg::MODE_OUT_PP
			|=> !pin_oe_n[g] && pin_out[g] == $past(port_output_data[g]))
			else $error("push-pull pin not following data");
		open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
			mode_d[g] == gpio_pkg::MODE_OUT_OD
			|=> !pin_out[g] && pin_oe_n[g] == $past(port_output_data[g]))
			else $error("open-drain pin wrong");
		pull_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
			mode_d[g] == gpio_pkg::MODE_IN_PULL
			|=> pin_oe_n[g] && (pin_pull_up[g] != pin_pull_down[g]))
			else $error("pulled input wrong");
		no_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
			!pin_oe_n[g] || $past(mode_d[g] == gpio_pkg::MODE_ANALOG)
			|-> !pin_pull_up[g] && !pin_pull_down[g])
			else $error("pull enabled on driven pin");
	end

endmodule
`default_nettype wire

/* File: dv/pin_board.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_board (
	input wire logic pclk,
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe_n,
	input wire logic [23:0] pin_pull_up,
	input wire logic [23:0] pin_pull_down,
	input wire logic [23:0] ext_level,
	input wire logic [23:0] ext_en,
	output logic [23:0] pin_in
);
	logic float_q = 1'b0;
	// an undriven wire must not settle to a convenient value
	always_ff @(posedge pclk) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (!pin_oe_n[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_level[i];
			else if (pin_pull_up[i])
				pin_in[i] = 1'b1;
			else if (pin_pull_down[i])
				pin_in[i] = 1'b0;
			else
				pin_in[i] = float_q;
		end
	end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gpio_consts.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd, w;
	logic [23:0] port_output_data, alt_out_data, pin_in, pin_out, pin_oe_n, pin_pull_up;
	logic [23:0] pin_pull_down, port_input_data, ext_level, ext_en;
	logic [3:0] timer_two_ch, e;
	logic reg_en_drive, debug_forced_in, serial_wire_req, four_wire_req, test_data_out;
	logic swdio_out, swdio_drive;
	int miscompares = 0, tests_run = 0, cycles = 0;
	logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD};
	logic [31:0] cfg_addr [6] = '{`CFG_PA_LOW, `CFG_PA_HIGH, `CFG_PB_LOW, `CFG_PB_HIGH,
		`CFG_PC_LOW, `CFG_PC_HIGH};
	gpio_pin_config_mux i_gpio_pin_config_mux (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .port_output_data, .alt_out_data,
		.timer_two_ch, .reg_en_drive, .debug_forced_in, .serial_wire_req, .four_wire_req,
		.test_data_out, .swdio_out, .swdio_drive, .pin_in, .pin_out, .pin_oe_n,
		.pin_pull_up, .pin_pull_down, .port_input_data);
	pin_board i_pin_board (.pclk, .pin_out, .pin_oe_n, .pin_pull_up, .pin_pull_down,
		.ext_level, .ext_en, .pin_in);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// generous ceiling: the whole sequence needs under 200 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task step(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	function automatic logic [3:0] exp_pin(logic [3:0] c, logic d, logic a);
		case (c)
			4'h1: return {d, 3'b000};
			4'h5: return {1'b0, d, 2'b00};
			4'h8: return {2'b01, d, ~d};
			4'h9: return {a, 3'b000};
			4'hD: return {1'b0, a, 2'b00};
			default: return 4'b0100;
		endcase
	endfunction
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{port_output_data, alt_out_data, timer_two_ch, ext_level, ext_en} = '0;
		{reg_en_drive, debug_forced_in, serial_wire_req, four_wire_req} = '0;
		{test_data_out, swdio_out, swdio_drive} = '0;
		void'($urandom(32'h3145B48F));
		step(12);
		chk(32'(pin_pull_up), 32'h20, "boot pull");
		@(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, cfg_addr[i], 32'h0);
			chk(rd, 32'h4444, "cfg reset");
		end
		apb(1'b0, `DBG_STAT_ADDR, 32'h0);
		chk(rd[2], 1'b0, "boot flag");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			w = $urandom;
			apb(1'b1, cfg_addr[i], w);
			apb(1'b0, cfg_addr[i], 32'h0);
			chk(rd, {16'h0, w[15:0]}, "cfg rw");
		end
		apb(1'b0, 32'h4000B008, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test registers done");
		ext_en[8] <= 1'b1;
		foreach (codes[k]) begin
			port_output_data <= $urandom;
			alt_out_data <= $urandom;
			ext_level <= $urandom;
			apb(1'b1, `CFG_PB_LOW, {28'h0000444, codes[k]});
			step(2);
			e = exp_pin(codes[k], port_output_data[8], alt_out_data[8]);
			chk({pin_out[8] & ~pin_oe_n[8], pin_oe_n[8], pin_pull_up[8], pin_pull_down[8]},
				e, "mode");
			if (codes[k] == 4'h0 || codes[k] == 4'h4)
				chk(port_input_data[8], codes[k] == 4'h0 || ext_level[8], "input");
		end
		$display("test modes done");
		timer_two_ch <= $urandom;
		apb(1'b1, `CFG_PA_LOW, 32'h4449);
		step(2);
		chk({pin_oe_n[0], pin_out[0]}, {1'b0, timer_two_ch[0]}, "timer");
		apb(1'b1, `DBG_CTL_ADDR, 32'h6);
		apb(1'b1, `CFG_PB_LOW, 32'h4494);
		step(2);
		chk({pin_oe_n[9], pin_out[9]}, {1'b0, timer_two_ch[0]}, "remap");
		reg_en_drive <= 1'b1;
		step(2);
		chk(pin_oe_n[7], 1'b1, "reg en");
		reg_en_drive <= 1'b0;
		step(2);
		chk({pin_oe_n[7], pin_out[7]}, 2'b00, "reg en");
		$display("test overrides done");
		four_wire_req <= 1'b1;
		test_data_out <= 1'b1;
		step(2);
		chk({pin_oe_n[18], pin_out[18]}, 2'b01, "tdo");
		chk({pin_pull_up[16], pin_pull_up[19], pin_oe_n[16]}, 3'b111, "tdi");
		serial_wire_req <= 1'b1;
		swdio_drive <= 1'b1;
		swdio_out <= $urandom;
		debug_forced_in <= 1'b1;
		step(2);
		chk({pin_oe_n[20], pin_out[20]}, {1'b0, swdio_out}, "swd out");
		apb(1'b0, `DBG_STAT_ADDR, 32'h0);
		chk(rd[1:0], 2'b11, "status");
		swdio_drive <= 1'b0;
		step(2);
		chk({pin_oe_n[20], pin_pull_up[20], pin_pull_down[20]}, 3'b100, "swd in");
		apb(1'b1, `DBG_CTL_ADDR, 32'h7);
		apb(1'b0, `DBG_STAT_ADDR, 32'h0);
		chk(rd[1], 1'b0, "disable");
		$display("test debug done");
		ext_en[5] <= 1'b1;
		ext_level[5] <= 1'b0;
		presetn <= 1'b0;
		step(3);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `DBG_STAT_ADDR, 32'h0);
		chk(rd[2], 1'b1, "boot seen");
		$display("test boot done");
		wrap_up();
	end
endmodule
`default_nettype wire
